// *** tacs_pkg.sv ***
`default_nettype none
// ==========================================================================
// shared constants for the alarm, configuration and status block
package tacs_pkg;
  // register pointer values that reach this block, and register reset values
  localparam logic [7:0] TACS_PTR_RESET = 8'h00;
  localparam logic [7:0] TACS_ADDR_CFG1 = 8'h41;
  localparam logic [7:0] TACS_ADDR_CFG2 = 8'h42;
  localparam logic [7:0] TACS_ADDR_CFG3 = 8'h43;
  localparam logic [7:0] TACS_ADDR_ST1 = 8'h44;
  localparam logic [7:0] TACS_ADDR_ST2 = 8'h45;
  localparam logic [7:0] TACS_ADDR_ST3 = 8'h46;
  localparam logic [7:0] TACS_CFG_RESET = 8'h00;
  localparam logic [7:0] TACS_ST_RESET = 8'h00;
  // operating_control bit positions
  localparam int TACS_CFG1_STANDBY = 7;
  localparam int TACS_CFG1_SOFTRST = 6;
  localparam int TACS_CFG1_TMO_DIS = 5;
  localparam int TACS_CFG1_FAST1 = 4;
  localparam int TACS_CFG1_RCAN = 3;
  // writable bits; the rest read as zero
  localparam logic [7:0] TACS_CFG1_WMASK = 8'hB8;
  localparam logic [7:0] TACS_CFG2_WMASK = 8'h4F;
  localparam logic [7:0] TACS_CFG3_WMASK = 8'h09;
  // overtemperature channels and their bits in mask and status
  localparam logic [2:0] TACS_OVT_CH_A = 3'h1;
  localparam logic [2:0] TACS_OVT_CH_B = 3'h4;
  localparam int TACS_OVT_BIT_A = 0;
  localparam int TACS_OVT_BIT_B = 3;
  localparam int TACS_LOCAL_BIT = 6;
  // 4 degree hysteresis at one degree per code
  localparam logic [8:0] TACS_OVT_HYST = 9'h004;
  localparam logic [7:0] TACS_FAULT_TEMP = 8'hFF;
  localparam logic [7:0] TACS_NO_REPLY = 8'hFF;
  localparam int TACS_NUM_CH = 5;
  // request kinds handed over from the bus engine
  typedef enum logic [2:0] {
    TACS_REQ_CMD = 3'b000,
    TACS_REQ_WR = 3'b001,
    TACS_REQ_RD = 3'b010,
    TACS_REQ_ARA = 3'b011,
    TACS_REQ_ARA_DONE = 3'b100
  } tacs_req_t;
  // link side handshake states
  typedef enum logic {
    TACS_LNK_IDLE = 1'b0,
    TACS_LNK_BUSY = 1'b1
  } tacs_lnk_st_t;
endpackage : tacs_pkg
`default_nettype wire

// *** tacs_alarm.sv ***
`timescale 1ns/100ps
`default_nettype none
// Function
// [R1] alert response returns own address when pending
// [R2] lost arbitration: no ack, alert kept
// [R3] completed alert response clears alert latch
// [R4] overtemp asserts when temperature above threshold
// [R5] overtemp holds until below threshold minus 4
// [R6] 8-bit pointer selects register, resets zero
// [R7] standby bit stops conversions
// [R8] soft reset bit restores power-on values
// [R9] timeout bit: zero enables, one disables
// [R10] fast channel-1 conversion enable bit
// [R11] channel-1 resistance cancellation enable bit
// [R12] low bits unused, register resets 00h
// [R13] alert masks for local and remote channels
// [R14] overtemp masks for channels 4 and 1
// [R15] status 1 flags alert limit exceeded
// [R16] status 2 flags overtemp threshold exceeded
// [R17] status 3 flags remote diode faults
// [R18] alert flags clear on read, re-set
// [R19] alert follows flags; read or response clears
// [R20] overtemp flags clear on read only
// [R21] alert never stalls conversion sequence
// [R22] diode fault sets flag, no alarms
// [R23] alert is open-drain active-low
// [R24] masked channels flag but drive nothing
module tacs_alarm #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2A  // arbitrary value
) (
  // clocks and reset
  input wire logic core_clk,
  input wire logic link_clk,
  input wire logic resetn,
  // bus engine requests, link clock domain
  input wire logic lk_req_valid,
  input wire logic [2:0] lk_req_kind,
  input wire logic [7:0] lk_req_data,
  output logic lk_req_ready,
  output logic lk_rsp_valid,
  output logic [7:0] lk_rsp_data,
  output logic lk_rsp_nack,
  // conversion results, core clock domain
  input wire logic conv_done,
  input wire logic [2:0] conv_ch,
  input wire logic [7:0] conv_temp,
  input wire logic conv_fault,
  // thresholds, alert_limit channel n at bits 8n+7:8n
  input wire logic [39:0] alert_limit,
  input wire logic [7:0] overtemp_alarm_out_limit_ch1,
  input wire logic [7:0] overtemp_alarm_out_limit_ch4,
  // alarm pins
  output logic alert_n_out,
  output logic alert_n_oe,
  output logic overtemp_alarm_out,
  // operating controls to the converter
  output logic standby,
  output logic timeout_dis,
  output logic fast_ch1,
  output logic res_cancel
);
  import tacs_pkg::*;

  // ========================================================================
  // helpers

  // one-hot status or mask bit of a channel
  function automatic logic [7:0] tacs_ch_bit(input logic [2:0] ch);
    logic [7:0] b;
    b = 8'h00;
    if (ch == 3'h0)
      b[TACS_LOCAL_BIT] = 1'b1;
    else
      b[ch - 3'h1] = 1'b1;
    return b;
  endfunction : tacs_ch_bit

  // temperature plus hysteresis still under the threshold
  function automatic logic tacs_below_hyst(input logic [7:0] t, input logic [7:0] lim);
    return ({1'b0, t} + TACS_OVT_HYST) < {1'b0, lim};
  endfunction : tacs_below_hyst

  // ========================================================================
  // link domain

  typedef struct packed {
    tacs_lnk_st_t st;
    logic [2:0] kind;
    logic [7:0] data;
    logic req_tgl;
    logic ack_s1;
    logic ack_s2;
    logic ack_s3;
    logic ready;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_nack;
  } tacs_lnk_t;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic rsp_tgl;
    logic [7:0] rsp_data;
    logic rsp_nack;
    logic [7:0] ptr;
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [7:0] cfg3;
    logic [7:0] st1;
    logic [7:0] st2;
    logic [7:0] st3;
    logic alert;
    logic ov_a;
    logic ov_b;
    logic ovt;
  } tacs_core_t;

  tacs_lnk_t l_q, l_d;
  tacs_core_t c_q, c_d;

  // capture a request, toggle it across, wait for the returned toggle
  always_comb
  begin
    l_d = l_q;
    l_d.ack_s1 = c_q.rsp_tgl;
    l_d.ack_s2 = l_q.ack_s1;
    l_d.ack_s3 = l_q.ack_s2;
    l_d.rsp_valid = 1'b0;
    case (l_q.st)
      TACS_LNK_IDLE:
      begin
        if (lk_req_valid)
        begin
          l_d.kind = lk_req_kind;
          l_d.data = lk_req_data;
          l_d.req_tgl = ~l_q.req_tgl;
          l_d.ready = 1'b0;
          l_d.st = TACS_LNK_BUSY;
        end
      end
      TACS_LNK_BUSY:
      begin
        if (l_q.ack_s2 != l_q.ack_s3)
        begin
          // core answer is stable once its toggle is seen here
          l_d.rsp_data = c_q.rsp_data;
          l_d.rsp_nack = c_q.rsp_nack;
          l_d.rsp_valid = 1'b1;
          l_d.ready = 1'b1;
          l_d.st = TACS_LNK_IDLE;
        end
      end
      default:
      begin
        l_d.st = TACS_LNK_IDLE;
        l_d.ready = 1'b1;
      end
    endcase
  end

  // link domain registers
  always_ff @(posedge link_clk or negedge resetn)
  begin
    if (!resetn)
      l_q <= '{st: TACS_LNK_IDLE, ready: 1'b1, default: '0};
    else
      l_q <= l_d;
  end

  // ========================================================================
  // core domain

  logic req_fire;
  logic soft_rst_w;
  logic [7:0] conv_bit;
  logic [7:0] conv_lim;
  logic conv_ok;

  assign req_fire = c_q.req_s2 ^ c_q.req_s3;
  assign soft_rst_w = req_fire && (l_q.kind == TACS_REQ_WR) && (c_q.ptr == TACS_ADDR_CFG1)
                      && l_q.data[TACS_CFG1_SOFTRST];
  assign conv_bit = tacs_ch_bit(conv_ch);
  assign conv_ok = conv_done && (int'(conv_ch) < TACS_NUM_CH);
  assign conv_lim = conv_ok ? alert_limit[int'(conv_ch) * 8 +: 8] : TACS_FAULT_TEMP;

  // request handling first, conversion results after so a set wins
  always_comb
  begin
    c_d = c_q;
    c_d.req_s1 = l_q.req_tgl;
    c_d.req_s2 = c_q.req_s1;
    c_d.req_s3 = c_q.req_s2;
    if (req_fire)
    begin
      c_d.rsp_tgl = ~c_q.rsp_tgl;
      c_d.rsp_nack = 1'b0;
      c_d.rsp_data = 8'h00;
      case (l_q.kind)
        TACS_REQ_CMD:
          c_d.ptr = l_q.data; // R6
        TACS_REQ_WR:
        begin
          case (c_q.ptr)
            TACS_ADDR_CFG1:
              c_d.cfg1 = l_q.data & TACS_CFG1_WMASK; // R12
            TACS_ADDR_CFG2:
              c_d.cfg2 = l_q.data & TACS_CFG2_WMASK; // R13
            TACS_ADDR_CFG3:
              c_d.cfg3 = l_q.data & TACS_CFG3_WMASK; // R14
            default:
              c_d.rsp_nack = 1'b0;
          endcase
        end
        TACS_REQ_RD:
        begin
          case (c_q.ptr)
            TACS_ADDR_CFG1:
              c_d.rsp_data = c_q.cfg1;
            TACS_ADDR_CFG2:
              c_d.rsp_data = c_q.cfg2;
            TACS_ADDR_CFG3:
              c_d.rsp_data = c_q.cfg3;
            TACS_ADDR_ST1:
            begin
              c_d.rsp_data = c_q.st1;
              c_d.st1 = TACS_ST_RESET; // R18
              c_d.alert = 1'b0; // R19
            end
            TACS_ADDR_ST2:
            begin
              // overtemp pin itself is left alone
              c_d.rsp_data = c_q.st2;
              c_d.st2 = TACS_ST_RESET; // R20
            end
            TACS_ADDR_ST3:
              c_d.rsp_data = c_q.st3; // R17
            default:
              c_d.rsp_data = 8'h00;
          endcase
        end
        TACS_REQ_ARA:
        begin
          if (c_q.alert)
            c_d.rsp_data = {SLAVE_ADDR, 1'b1}; // R1
          else
          begin
            c_d.rsp_data = TACS_NO_REPLY;
            c_d.rsp_nack = 1'b1;
          end
        end
        TACS_REQ_ARA_DONE:
          // sent only after arbitration was won; a loser keeps its alert
          c_d.alert = 1'b0; // R3 R2
        default:
          c_d.rsp_nack = 1'b1;
      endcase
    end
    // conversion end; never gated by the alert state
    if (conv_ok && !soft_rst_w) // R21
    begin
      if (conv_fault && conv_ch != 3'h0)
        c_d.st3 = c_q.st3 | conv_bit; // R22
      else
      begin
        if (conv_ch != 3'h0)
          c_d.st3 = c_d.st3 & ~conv_bit; // R17
        if (conv_temp > conv_lim)
        begin
          c_d.st1 = c_d.st1 | conv_bit; // R15
          if ((c_q.cfg2 & conv_bit) == 8'h00)
            c_d.alert = 1'b1; // R19 R24
        end
        if (conv_ch == TACS_OVT_CH_A)
        begin
          if (conv_temp > overtemp_alarm_out_limit_ch1)
          begin
            c_d.st2[TACS_OVT_BIT_A] = 1'b1; // R16
            c_d.ov_a = 1'b1; // R4
          end
          else if (tacs_below_hyst(conv_temp, overtemp_alarm_out_limit_ch1))
            c_d.ov_a = 1'b0; // R5
        end
        if (conv_ch == TACS_OVT_CH_B)
        begin
          if (conv_temp > overtemp_alarm_out_limit_ch4)
          begin
            c_d.st2[TACS_OVT_BIT_B] = 1'b1; // R16
            c_d.ov_b = 1'b1; // R4
          end
          else if (tacs_below_hyst(conv_temp, overtemp_alarm_out_limit_ch4))
            c_d.ov_b = 1'b0; // R5
        end
      end
    end
    // soft reset restores every register, handshake state kept
    if (soft_rst_w)
    begin
      c_d.ptr = TACS_PTR_RESET; // R8
      c_d.cfg1 = TACS_CFG_RESET;
      c_d.cfg2 = TACS_CFG_RESET;
      c_d.cfg3 = TACS_CFG_RESET;
      c_d.st1 = TACS_ST_RESET;
      c_d.st2 = TACS_ST_RESET;
      c_d.st3 = TACS_ST_RESET;
      c_d.alert = 1'b0;
      c_d.ov_a = 1'b0;
      c_d.ov_b = 1'b0;
    end
    // masked channels keep their hysteresis state but cannot drive the pin
    c_d.ovt = (c_d.ov_a && !c_d.cfg3[TACS_OVT_BIT_A]) || (c_d.ov_b && !c_d.cfg3[TACS_OVT_BIT_B]); // R14 R24
  end

  // core domain registers
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      c_q <= '0;
    else
      c_q <= c_d;
  end

  // ========================================================================
  // outputs

  // link answers
  assign lk_req_ready = l_q.ready;
  assign lk_rsp_valid = l_q.rsp_valid;
  assign lk_rsp_data = l_q.rsp_data;
  assign lk_rsp_nack = l_q.rsp_nack;
  // open-drain alert: drive low while pending
  assign alert_n_out = c_q.cfg1[0]; // always zero, bit never writable
  assign alert_n_oe = c_q.alert; // R23
  assign overtemp_alarm_out = c_q.ovt;
  // operating controls
  assign standby = c_q.cfg1[TACS_CFG1_STANDBY]; // R7
  assign timeout_dis = c_q.cfg1[TACS_CFG1_TMO_DIS]; // R9
  assign fast_ch1 = c_q.cfg1[TACS_CFG1_FAST1]; // R10
  assign res_cancel = c_q.cfg1[TACS_CFG1_RCAN]; // R11

  // ========================================================================
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  logic is_rd;
  logic conv_a_hi;
  logic conv_a_lo;
  assign is_rd = req_fire && (l_q.kind == TACS_REQ_RD);
  assign conv_a_hi = conv_ok && !conv_fault && conv_ch == TACS_OVT_CH_A && conv_temp > overtemp_alarm_out_limit_ch1;
  assign conv_a_lo = conv_ok && !conv_fault && conv_ch == TACS_OVT_CH_A
                     && tacs_below_hyst(conv_temp, overtemp_alarm_out_limit_ch1);

  soft_reset_a: assert property (soft_rst_w |=> c_q.cfg1 == 8'h00 && c_q.ptr == 8'h00 && !alert_n_oe) // R8
    else $error("soft reset did not restore registers");
  overtemp_alarm_out_set_a: assert property (conv_a_hi && !soft_rst_w && !c_d.cfg3[TACS_OVT_BIT_A] |=> overtemp_alarm_out) // R4
    else $error("overtemp not raised above threshold");
  overtemp_alarm_out_hold_a: assert property ($fell(c_q.ov_a) |-> $past(conv_a_lo || soft_rst_w)) // R5
    else $error("overtemp released inside hysteresis band");
  alert_rise_a: assert property ($rose(alert_n_oe) |-> $past(conv_ok && !(conv_fault && conv_ch != 3'h0))) // R19
    else $error("alert rose without a conversion");
  st1_clear_a: assert property (is_rd && c_q.ptr == TACS_ADDR_ST1 && !conv_done |=> c_q.st1 == 8'h00 && !alert_n_oe) // R18
    else $error("status 1 read did not clear");
  st2_keep_a: assert property (is_rd && c_q.ptr == TACS_ADDR_ST2 && !conv_done
                               |=> c_q.st2 == 8'h00 && $stable(overtemp_alarm_out)) // R20
    else $error("status 2 read misbehaved");
  fault_quiet_a: assert property (conv_ok && conv_fault && conv_ch != 3'h0
                                  |=> !$rose(alert_n_oe) && !$rose(overtemp_alarm_out)) // R22
    else $error("diode fault raised an alarm");
  ara_reply_a: assert property (req_fire && l_q.kind == TACS_REQ_ARA && c_q.alert
                                |=> c_q.rsp_data == {SLAVE_ADDR, 1'b1} && !c_q.rsp_nack) // R1
    else $error("alert response address wrong");
  ara_clear_a: assert property (req_fire && l_q.kind == TACS_REQ_ARA_DONE && !conv_done |=> !alert_n_oe) // R3
    else $error("alert response did not clear alert");
  mask_keep_a: assert property (conv_ok && !conv_fault && conv_temp > conv_lim && (c_q.cfg2 & conv_bit) != 8'h00
                                && !alert_n_oe && !soft_rst_w |=> (c_q.st1 & conv_bit) != 8'h00 && !alert_n_oe) // R24
    else $error("masked channel flag or alert wrong");
  link_answer_a: assert property (@(posedge link_clk) disable iff (!resetn)
                                  lk_req_valid && lk_req_ready |-> ##[4:12] lk_rsp_valid) // R6
    else $error("link request not answered in time");

  alert_seen_c: cover property ($rose(alert_n_oe));
  overtemp_alarm_out_cycle_c: cover property ($rose(overtemp_alarm_out) ##[1:200] $fell(overtemp_alarm_out));
  ara_win_c: cover property (req_fire && l_q.kind == TACS_REQ_ARA && c_q.alert);
endmodule : tacs_alarm
`default_nettype wire

// *** tacs_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// bus engine stand-in: one request at a time on the link side
module tacs_host_model (
  // link clock
  input wire logic link_clk,
  // request side
  output logic lk_req_valid,
  output logic [2:0] lk_req_kind,
  output logic [7:0] lk_req_data,
  // answer side
  input wire logic lk_req_ready,
  input wire logic lk_rsp_valid,
  input wire logic [7:0] lk_rsp_data,
  input wire logic lk_rsp_nack
);
  // idle request lines
  initial
  begin
    lk_req_valid = 1'b0;
    lk_req_kind = 3'h7;
    lk_req_data = 8'hA5;
  end

  // present a request, hold it until taken, then wait for the answer
  task automatic xfer(input logic [2:0] kind, input logic [7:0] data, output logic [7:0] rdata,
                      output logic nack, output logic ok);
    int n;
    ok = 1'b0;
    rdata = 8'h00;
    nack = 1'b0;
    n = 0;
    @(posedge link_clk);
    #1;
    lk_req_valid = 1'b1;
    lk_req_kind = kind;
    lk_req_data = data;
    do
    begin
      @(posedge link_clk);
      n++;
    end
    while (lk_req_ready !== 1'b1 && n < 20);
    #1;
    lk_req_valid = 1'b0;
    lk_req_kind = ~kind;  // released lines show the inverse of the last value
    lk_req_data = ~data;
    for (n = 0; n < 20 && !ok; n++)
    begin
      @(posedge link_clk);
      if (lk_rsp_valid === 1'b1)
      begin
        ok = 1'b1;
        rdata = lk_rsp_data;
        nack = lk_rsp_nack;
      end
    end
  endtask : xfer
endmodule : tacs_host_model
`default_nettype wire

// *** tacs_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// self-checking bench for the alarm, configuration and status block
module testbench;
  import tacs_pkg::*;
  localparam logic [6:0] OWN_ADDR = 7'h2A;  // arbitrary value
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic resetn = 1'b0;
  logic lk_req_valid, lk_req_ready, lk_rsp_valid, lk_rsp_nack;
  logic [2:0] lk_req_kind;
  logic [7:0] lk_req_data, lk_rsp_data;
  logic conv_done = 1'b0;
  logic [2:0] conv_ch = 3'h0;
  logic [7:0] conv_temp = 8'h00;
  logic conv_fault = 1'b0;
  logic [39:0] alert_limit = 40'hFFFF_FFFF_FF;
  logic [7:0] overtemp_alarm_out_limit_ch1 = 8'hFF;
  logic [7:0] overtemp_alarm_out_limit_ch4 = 8'hFF;
  logic alert_n_out, alert_n_oe, overtemp_alarm_out, standby, timeout_dis, fast_ch1, res_cancel;
  logic [7:0] rsp_byte;
  logic rsp_nack_seen, rsp_ok;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;

  // clocks, link clock offset so the phases never line up
  always #20 core_clk = ~core_clk;
  initial
  begin
    #7;
    forever #16 link_clk = ~link_clk;
  end

  // ========================================================================
  // design and link partner
  tacs_alarm #(.SLAVE_ADDR(OWN_ADDR)) i_dut (.core_clk, .link_clk, .resetn, .lk_req_valid, .lk_req_kind,
    .lk_req_data, .lk_req_ready, .lk_rsp_valid, .lk_rsp_data, .lk_rsp_nack, .conv_done, .conv_ch,
    .conv_temp, .conv_fault, .alert_limit, .overtemp_alarm_out_limit_ch1, .overtemp_alarm_out_limit_ch4, .alert_n_out,
    .alert_n_oe, .overtemp_alarm_out, .standby, .timeout_dis, .fast_ch1, .res_cancel);
  tacs_host_model i_host (.link_clk, .lk_req_valid, .lk_req_kind, .lk_req_data, .lk_req_ready,
    .lk_rsp_valid, .lk_rsp_data, .lk_rsp_nack);

  // ========================================================================
  // shared helpers
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic pins(input logic a, input logic o);
    chk("alarm_pins", {5'h00, 1'b0, a, o}, {5'h00, alert_n_out, alert_n_oe, overtemp_alarm_out});
  endtask : pins

  task automatic ops(input logic [3:0] e);
    chk("op_ctrl", {4'h0, e}, {4'h0, standby, timeout_dis, fast_ch1, res_cancel});
  endtask : ops

  task automatic req(input logic [2:0] kind, input logic [7:0] data);
    i_host.xfer(kind, data, rsp_byte, rsp_nack_seen, rsp_ok);
    chk("answered", 8'h01, {7'h00, rsp_ok});
  endtask : req

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    req(TACS_REQ_CMD, addr);
    req(TACS_REQ_WR, data);
  endtask : wr

  task automatic rd(input string what, input logic [7:0] addr, input logic [7:0] exp);
    req(TACS_REQ_CMD, addr);
    req(TACS_REQ_RD, 8'h00);
    chk(what, exp, rsp_byte);
  endtask : rd

  // one conversion result, outputs settled after two more edges
  task automatic conv(input logic [2:0] ch, input logic [7:0] temp, input logic fault);
    @(posedge core_clk);
    #1;
    conv_done = 1'b1;
    conv_ch = ch;
    conv_temp = temp;
    conv_fault = fault;
    @(posedge core_clk);
    #1;
    conv_done = 1'b0;
    conv_fault = 1'b0;
    @(posedge core_clk);
    #1;
  endtask : conv

  task automatic query(input logic [7:0] exp, input logic nack);
    req(TACS_REQ_ARA, 8'h00);
    chk("query_data", exp, rsp_byte);
    chk("query_nack", {7'h00, nack}, {7'h00, rsp_nack_seen});
  endtask : query

  // ========================================================================
  // scenarios
  task automatic t_reset;
    pins(1'b0, 1'b0);
    ops(4'h0);
    // a data write at the reset pointer must land in no configuration register
    req(TACS_REQ_WR, 8'hBF);
    req(TACS_REQ_RD, 8'h00);
    chk("pointer_reset", 8'h00, rsp_byte);
    rd("cfg1_reset", TACS_ADDR_CFG1, 8'h00);
    rd("cfg2_reset", TACS_ADDR_CFG2, 8'h00);
    rd("cfg3_reset", TACS_ADDR_CFG3, 8'h00);
  endtask : t_reset

  task automatic t_config;
    wr(TACS_ADDR_CFG1, 8'hBF);
    rd("cfg1_bits", TACS_ADDR_CFG1, 8'hB8);
    ops(4'hF);
    wr(TACS_ADDR_CFG1, 8'h98);
    ops(4'hB);
    wr(TACS_ADDR_CFG2, 8'hFF);
    rd("cfg2_bits", TACS_ADDR_CFG2, 8'h4F);
    wr(TACS_ADDR_CFG3, 8'hFF);
    rd("cfg3_bits", TACS_ADDR_CFG3, 8'h09);
    wr(TACS_ADDR_CFG1, 8'h40);
    ops(4'h0);
    rd("cfg1_soft", TACS_ADDR_CFG1, 8'h00);
    rd("cfg2_soft", TACS_ADDR_CFG2, 8'h00);
    rd("cfg3_soft", TACS_ADDR_CFG3, 8'h00);
  endtask : t_config

  task automatic t_alert;
    alert_limit = 40'hFFFF_FF50_30;
    conv(3'h1, 8'h50, 1'b0);
    pins(1'b0, 1'b0);
    conv(3'h1, 8'h51, 1'b0);
    pins(1'b1, 1'b0);
    query({OWN_ADDR, 1'b1}, 1'b0);
    pins(1'b1, 1'b0);
    query({OWN_ADDR, 1'b1}, 1'b0);
    req(TACS_REQ_ARA_DONE, 8'h00);
    pins(1'b0, 1'b0);
    conv(3'h1, 8'h51, 1'b0);
    pins(1'b1, 1'b0);
    rd("status1", TACS_ADDR_ST1, 8'h01);
    pins(1'b0, 1'b0);
    rd("status1_again", TACS_ADDR_ST1, 8'h00);
    query(TACS_NO_REPLY, 1'b1);
    wr(TACS_ADDR_CFG2, 8'h41);
    conv(3'h1, 8'h51, 1'b0);
    conv(3'h0, 8'h31, 1'b0);
    pins(1'b0, 1'b0);
    rd("status1_masked", TACS_ADDR_ST1, 8'h41);
    wr(TACS_ADDR_CFG2, 8'h00);
  endtask : t_alert

  task automatic t_overtemp_alarm_out;
    alert_limit = 40'hFFFF_FFFF_FF;
    overtemp_alarm_out_limit_ch1 = 8'h60;
    overtemp_alarm_out_limit_ch4 = 8'h40;
    conv(3'h1, 8'h60, 1'b0);
    pins(1'b0, 1'b0);
    conv(3'h1, 8'h61, 1'b0);
    pins(1'b0, 1'b1);
    rd("status2", TACS_ADDR_ST2, 8'h01);
    pins(1'b0, 1'b1);
    rd("status2_again", TACS_ADDR_ST2, 8'h00);
    wr(TACS_ADDR_CFG3, 8'h08);
    conv(3'h4, 8'h41, 1'b0);
    rd("status2_masked", TACS_ADDR_ST2, 8'h08);
    conv(3'h1, 8'h5C, 1'b0);
    pins(1'b0, 1'b1);
    conv(3'h1, 8'h5B, 1'b0);
    pins(1'b0, 1'b0);
    wr(TACS_ADDR_CFG3, 8'h00);
    conv(3'h4, 8'h41, 1'b0);
    pins(1'b0, 1'b1);
  endtask : t_overtemp_alarm_out

  task automatic t_fault;
    alert_limit = 40'hFFFF_10FF_FF;
    conv(3'h2, TACS_FAULT_TEMP, 1'b1);
    pins(1'b0, 1'b1);
    rd("status3", TACS_ADDR_ST3, 8'h02);
    rd("status1_fault", TACS_ADDR_ST1, 8'h00);
    conv(3'h2, 8'h05, 1'b0);
    rd("status3_good", TACS_ADDR_ST3, 8'h00);
  endtask : t_fault

  // ========================================================================
  // closing report
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // main sequence after six reset cycles
  initial
  begin
    repeat (6) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    t_reset();
    t_config();
    t_alert();
    t_overtemp_alarm_out();
    t_fault();
    summarize();
  end

  // cut a hang short
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      summarize();
    end
  end
endmodule : testbench
`default_nettype wire
